// [cfg_upper_pkg.sv]
// constants for the upper config header registers
// assumes a 100 MHz PCI clock and dword-indexed config cycles
package cfg_upper_pkg;
	// config byte offsets
	localparam logic [7:0]  CSR_BASE_OFF = 8'h14;
	localparam logic [7:0]  SUBSYS_OFF   = 8'h2C;
	localparam logic [7:0]  ROM_BASE_OFF = 8'h30;
	localparam logic [7:0]  INT_CFG_OFF  = 8'h3C;
	localparam logic [7:0]  SCRATCH_OFF  = 8'h40;

	// field positions
	localparam int          CSR_BASE_LSB = 7;
	localparam int          ROM_BASE_LSB = 18;
	localparam int          ROM_EN_BIT   = 0;

	// fixed field values
	localparam logic [7:0]  MAX_LATENCY_FIELD_VAL  = 8'h28;
	localparam logic [7:0]  MIN_GNT_VAL  = 8'h14;
	localparam logic [7:0]  INT_PIN_VAL  = 8'h01;

	// reset values of writable fields
	localparam logic [24:0] CSR_BASE_RST = 25'h0000000;
	localparam logic [13:0] ROM_BASE_RST = 14'h0000;
	localparam logic [7:0]  INT_LINE_RST = 8'h00;
	localparam logic [31:0] SCRATCH_RST  = 32'h00000000;

	// serial rom image: 32 data bits then an 8-bit checksum
	localparam int          ROM_BITS     = 40;

	// load period
	localparam int          CLK_PERIOD_NS = 10;
	localparam int          LOAD_TIME_NS  = 1230000;
	localparam int          LOAD_CYCLES   =
		(LOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : cfg_upper_pkg

// [subsys_id_loader.sv]
// serial rom reader for the subsystem identification word
// assumes a serial rom that shifts one bit per rising rom_sclk
`timescale 1ns/10ps
`default_nettype none

module subsys_id_loader #(
	parameter int BIT_CYCLES = 3075
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	// serial rom pins
	output logic             rom_cs,
	output logic             rom_sclk,
	input  wire logic        rom_sdata,
	// loaded word
	output logic [31:0]      id_word,
	output logic             id_loaded
);
	localparam int DW = $clog2(BIT_CYCLES + 1);

	typedef enum logic [2:0] {
		LD_SHIFT = 3'b001,
		LD_CHECK = 3'b010,
		LD_DONE  = 3'b100
	} load_state_type;

	typedef struct packed {
		load_state_type state;
		logic [1:0]     sync;
		logic [DW-1:0]  div;
		logic [5:0]     bits;
		logic [39:0]    shreg;
		logic [31:0]    word;
		logic           loaded;
		logic           cs;
		logic           sclk;
	} loader_type;

	loader_type st;
	loader_type next_st;
	logic [7:0] sum;
	logic       sum_ok;

	// checksum is the byte sum of the four data bytes
	assign sum = st.shreg[39:32] + st.shreg[31:24] + st.shreg[23:16] + st.shreg[15:8];
	assign sum_ok = (sum == st.shreg[7:0]);

	always_comb begin
		next_st = st;
		next_st.sync = {st.sync[0], rom_sdata};
		case (st.state)
			// RULE4 shift after reset
			LD_SHIFT: begin
				next_st.cs = 1'b1;
				if (st.div == DW'(BIT_CYCLES - 1)) begin
					next_st.div = '0;
					next_st.sclk = 1'b0;
					next_st.shreg = {st.shreg[38:0], st.sync[1]};
					if (st.bits == 6'(cfg_upper_pkg::ROM_BITS - 1)) begin
						next_st.state = LD_CHECK;
						next_st.cs = 1'b0;
					end else begin
						next_st.bits = st.bits + 6'h01;
					end
				end else begin
					next_st.div = st.div + DW'(1);
					next_st.sclk = (st.div >= DW'(BIT_CYCLES / 2));
				end
			end
			// RULE7 zero on bad checksum
			LD_CHECK: begin
				next_st.word = sum_ok ? st.shreg[39:8] : 32'h00000000;
				next_st.loaded = 1'b1;
				next_st.state = LD_DONE;
			end
			LD_DONE: begin
				next_st.cs = 1'b0;
			end
			default: begin
				next_st.state = LD_SHIFT;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			st <= '{state: LD_SHIFT, default: '0};
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign rom_cs = st.cs;
	assign rom_sclk = st.sclk;
	assign id_word = st.word;
	assign id_loaded = st.loaded;

	// cycles spent before the word is published
	logic [31:0] elapsed;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			elapsed <= 32'h00000000;
		end else if (ce && !st.loaded) begin
			elapsed <= elapsed + 32'h00000001;
		end
	end

	AST_BAD_SUM_ZERO: assert property (@(posedge clk) disable iff (!rstn) // RULE7
		(ce && st.state == LD_CHECK && !sum_ok) |=> (id_word == 32'h00000000 && id_loaded))
		else $error("bad checksum did not clear the word");
	AST_LOAD_SPAN: assert property (@(posedge clk) disable iff (!rstn) // RULE5
		$rose(id_loaded) |-> (elapsed >= 32'(cfg_upper_pkg::ROM_BITS * BIT_CYCLES)))
		else $error("word published before the load period");
endmodule : subsys_id_loader

`default_nettype wire

// [pci_config_space_upper_regs.sv]
// config registers 14h..40h of the controller's PCI header
// assumes a config front end that turns cycles into req/ack/retry
`timescale 1ns/10ps
`default_nettype none

// Function
// RULE1: memory base bits 31:7 are writable and set the csr decode address.
// RULE2: memory base bit 0 reads zero, marking memory space.
// RULE3: memory base bits 6:1 always read zero.
// RULE4: subsystem word is loaded from the serial rom right after reset.
// RULE5: the serial rom load takes about 1.23 ms.
// RULE6: subsystem register access during the load ends in retry.
// RULE7: failed rom checksum makes the subsystem word zero.
// RULE8: subsystem id in bits 31:16, vendor id in bits 15:0.
// RULE9: rom base in bits 31:10, bits 17:10 hardwired zero.
// RULE10: rom base bits 9:1 always read zero.
// RULE11: rom accesses claimed only with rom enable and memory space set.
// RULE12: host programs the rom base before touching the rom.
// RULE13: bits 31:24 report how often bus access is needed.
// RULE14: bits 23:16 report the needed burst length.
// RULE15: bits 15:8 read 01h, the first interrupt pin.
// RULE16: firmware writes the interrupt line byte; it is stored and read back.
// RULE17: register at 40h is free storage for the driver.
// RULE18: memory accesses answered only while memory space is enabled.
// RULE19: host programs the memory base before csr memory accesses.
// RULE20: writes to fixed or loaded fields are ignored.
module pci_config_space_upper_regs #(
	parameter int LOAD_CYCLES = cfg_upper_pkg::LOAD_CYCLES
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	// config access
	input  wire logic        cfg_req,
	input  wire logic        cfg_we,
	input  wire logic [5:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic             cfg_ack,
	output logic             cfg_retry,
	output logic [31:0]      cfg_rdata,
	// command register input
	input  wire logic        mem_space_en,
	// memory decode
	input  wire logic        mem_req,
	input  wire logic [31:0] mem_addr,
	output logic             csr_hit,
	output logic             rom_hit,
	// serial rom
	output logic             rom_cs,
	output logic             rom_sclk,
	input  wire logic        rom_sdata
);
	typedef struct packed {
		logic [24:0] csr_base;
		logic [13:0] rom_base;
		logic        rom_en;
		logic [7:0]  int_line;
		logic [31:0] scratch;
		logic        ack;
		logic        retry;
		logic [31:0] rdata;
	} regs_type;

	regs_type st;
	regs_type next_st;

	logic [31:0] id_word;
	logic        id_loaded;
	logic [7:0]  byte_addr;
	logic [31:0] img_base;
	logic [31:0] img_rom;
	logic [31:0] img_int;
	logic [31:0] rd_img;
	logic [31:0] wr_img;
	logic        is_subsys;

	// RULE4 load after reset
	subsys_id_loader #(
		.BIT_CYCLES (LOAD_CYCLES / cfg_upper_pkg::ROM_BITS)
	) u_loader (
		.clk       (clk),
		.rstn      (rstn),
		.ce        (ce),
		.rom_cs    (rom_cs),
		.rom_sclk  (rom_sclk),
		.rom_sdata (rom_sdata),
		.id_word   (id_word),
		.id_loaded (id_loaded)
	);

	function automatic logic [31:0] merge_bytes(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = new_v[8*i +: 8];
			end
		end
		return r;
	endfunction : merge_bytes

	assign byte_addr = {cfg_addr, 2'b00};
	assign is_subsys = (byte_addr == cfg_upper_pkg::SUBSYS_OFF);

	// RULE2 RULE3 low bits fixed
	assign img_base = {st.csr_base, 6'h00, 1'b0};
	// RULE9 RULE10 size bits fixed
	assign img_rom = {st.rom_base, 8'h00, 9'h000, st.rom_en};
	// RULE13 RULE14 RULE15 fixed bytes
	assign img_int = {cfg_upper_pkg::MAX_LATENCY_FIELD_VAL, cfg_upper_pkg::MIN_GNT_VAL,
		cfg_upper_pkg::INT_PIN_VAL, st.int_line};

	// read image of the addressed register
	always_comb begin
		case (byte_addr)
			cfg_upper_pkg::CSR_BASE_OFF: begin
				rd_img = img_base;
			end
			// RULE8 id halves
			cfg_upper_pkg::SUBSYS_OFF: begin
				rd_img = id_word;
			end
			cfg_upper_pkg::ROM_BASE_OFF: begin
				rd_img = img_rom;
			end
			cfg_upper_pkg::INT_CFG_OFF: begin
				rd_img = img_int;
			end
			cfg_upper_pkg::SCRATCH_OFF: begin
				rd_img = st.scratch;
			end
			default: begin
				rd_img = 32'h00000000;
			end
		endcase
	end

	assign wr_img = merge_bytes(rd_img, cfg_wdata, cfg_be);

	always_comb begin
		next_st = st;
		next_st.ack = 1'b0;
		next_st.retry = 1'b0;
		if (cfg_req) begin
			if (is_subsys && !id_loaded) begin
				// RULE6 retry while loading
				next_st.retry = 1'b1;
			end else begin
				next_st.ack = 1'b1;
				next_st.rdata = cfg_we ? st.rdata : rd_img;
			end
			if (cfg_we) begin
				// RULE20 fixed bits dropped
				case (byte_addr)
					// RULE1 base writable
					cfg_upper_pkg::CSR_BASE_OFF: begin
						next_st.csr_base = wr_img[31:cfg_upper_pkg::CSR_BASE_LSB];
					end
					// RULE9 upper rom base
					cfg_upper_pkg::ROM_BASE_OFF: begin
						next_st.rom_base = wr_img[31:cfg_upper_pkg::ROM_BASE_LSB];
						next_st.rom_en = wr_img[cfg_upper_pkg::ROM_EN_BIT];
					end
					// RULE16 keep line byte
					cfg_upper_pkg::INT_CFG_OFF: begin
						next_st.int_line = wr_img[7:0];
					end
					// RULE17 driver storage
					cfg_upper_pkg::SCRATCH_OFF: begin
						next_st.scratch = wr_img;
					end
					default: begin
						next_st.scratch = st.scratch;
					end
				endcase
			end
		end
	end

	// bases reset to zero; the host must program them before use (RULE12, RULE19)
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st <= '{csr_base: cfg_upper_pkg::CSR_BASE_RST,
				rom_base: cfg_upper_pkg::ROM_BASE_RST,
				rom_en: 1'b0,
				int_line: cfg_upper_pkg::INT_LINE_RST,
				scratch: cfg_upper_pkg::SCRATCH_RST,
				default: '0};
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign cfg_ack = st.ack;
	assign cfg_retry = st.retry;
	assign cfg_rdata = st.rdata;

	// RULE18 memory space gate
	assign csr_hit = mem_req && mem_space_en &&
		(mem_addr[31:cfg_upper_pkg::CSR_BASE_LSB] == st.csr_base);
	// RULE11 rom needs both enables
	assign rom_hit = mem_req && mem_space_en && st.rom_en &&
		(mem_addr[31:cfg_upper_pkg::ROM_BASE_LSB] == st.rom_base);

	// address of the last request seen while ce is high, retried or not, for the checks below
	// a write ack leaves the last read data on cfg_rdata, so field checks look at reads only
	logic [7:0] chk_addr;
	logic       chk_rd;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			chk_addr <= 8'h00;
			chk_rd <= 1'b0;
		end else if (ce && cfg_req) begin
			chk_addr <= byte_addr;
			chk_rd <= !cfg_we;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	AST_BASE_WRITE: assert property ( // RULE1
		(ce && cfg_req && cfg_we && byte_addr == cfg_upper_pkg::CSR_BASE_OFF && cfg_be == 4'hF)
		|=> st.csr_base == $past(cfg_wdata[31:7]))
		else $error("memory base not written");
	AST_BASE_BIT0: assert property ( // RULE2
		(cfg_ack && chk_rd && chk_addr == cfg_upper_pkg::CSR_BASE_OFF) |-> !cfg_rdata[0])
		else $error("memory base bit 0 not zero");
	AST_BASE_LOW: assert property ( // RULE3
		(cfg_ack && chk_rd && chk_addr == cfg_upper_pkg::CSR_BASE_OFF) |-> cfg_rdata[6:1] == 6'h00)
		else $error("memory base bits 6:1 not zero");
	AST_RETRY_LOAD: assert property ( // RULE6
		(ce && cfg_req && is_subsys && !id_loaded) |=> (cfg_retry && !cfg_ack))
		else $error("access during load not retried");
	AST_ROM_SIZE: assert property ( // RULE9
		(cfg_ack && chk_rd && chk_addr == cfg_upper_pkg::ROM_BASE_OFF) |-> cfg_rdata[17:10] == 8'h00)
		else $error("rom size bits not zero");
	AST_ROM_LOW: assert property ( // RULE10
		(cfg_ack && chk_rd && chk_addr == cfg_upper_pkg::ROM_BASE_OFF) |-> cfg_rdata[9:1] == 9'h000)
		else $error("rom bits 9:1 not zero");
	AST_ROM_CLAIM: assert property ( // RULE11
		rom_hit |-> (st.rom_en && mem_space_en))
		else $error("rom claimed while disabled");
	AST_INT_FIXED: assert property ( // RULE15
		(cfg_ack && chk_rd && chk_addr == cfg_upper_pkg::INT_CFG_OFF) |-> cfg_rdata[31:8] == 24'h281401)
		else $error("fixed interrupt bytes wrong");
	AST_MAX_LATENCY_FIELD: assert property ( // RULE13
		(cfg_ack && chk_rd && chk_addr == cfg_upper_pkg::INT_CFG_OFF)
		|-> cfg_rdata[31:24] == cfg_upper_pkg::MAX_LATENCY_FIELD_VAL)
		else $error("bus access interval byte wrong");
	AST_MIN_GNT: assert property ( // RULE14
		(cfg_ack && chk_rd && chk_addr == cfg_upper_pkg::INT_CFG_OFF)
		|-> cfg_rdata[23:16] == cfg_upper_pkg::MIN_GNT_VAL)
		else $error("burst length byte wrong");
	AST_ID_HALVES: assert property ( // RULE8
		(cfg_ack && chk_rd && chk_addr == cfg_upper_pkg::SUBSYS_OFF) |-> cfg_rdata == id_word)
		else $error("subsystem word not returned");
	AST_RETRY_SUBSYS: assert property ( // RULE6
		cfg_retry |-> (chk_addr == cfg_upper_pkg::SUBSYS_OFF && !cfg_ack))
		else $error("retry outside the subsystem register");
	AST_WRITE_RDATA: assert property ( // RULE20
		(ce && cfg_req && cfg_we) |=> cfg_rdata == $past(cfg_rdata))
		else $error("write disturbed read data");
	AST_LINE_KEEP: assert property ( // RULE16
		(ce && cfg_req && cfg_we && byte_addr == cfg_upper_pkg::INT_CFG_OFF && cfg_be[0])
		|=> st.int_line == $past(cfg_wdata[7:0]))
		else $error("interrupt line not stored");
	AST_SCRATCH: assert property ( // RULE17
		(ce && cfg_req && cfg_we && byte_addr == cfg_upper_pkg::SCRATCH_OFF && cfg_be == 4'hF)
		|=> st.scratch == $past(cfg_wdata))
		else $error("driver area not written");
	AST_MEM_GATE: assert property ( // RULE18
		!mem_space_en |-> (!csr_hit && !rom_hit))
		else $error("memory claim while disabled");
	AST_SUBSYS_RO: assert property ( // RULE20
		(id_loaded && ce && cfg_req && cfg_we && is_subsys) |=> id_word == $past(id_word))
		else $error("subsystem word changed by write");

	COV_RETRY: cover property (cfg_retry);
	COV_CSR_HIT: cover property (csr_hit);
	COV_ROM_HIT: cover property (rom_hit);
	COV_LOADED: cover property ($rose(id_loaded));
	COV_ROM_READ: cover property (cfg_ack && chk_rd && chk_addr == cfg_upper_pkg::ROM_BASE_OFF);
endmodule : pci_config_space_upper_regs

`default_nettype wire

// [serial_rom_model.sv]
// serial rom model holding the subsystem word and its checksum
// assumes the reader takes one bit per rising rom_sclk while rom_cs is high
`timescale 1ns/10ps
`default_nettype none

module serial_rom_model #(
	// arbitrary value, names no real part
	parameter logic [31:0] ID_WORD = 32'h3C5A0F1E
) (
	// rom pins
	input  wire logic rom_cs,
	input  wire logic rom_sclk,
	output logic      rom_sdata,
	// fault control
	input  wire logic corrupt
);
	logic [7:0]  sum;
	logic [39:0] image;
	logic        last;
	int          idx;

	assign sum = ID_WORD[31:24] + ID_WORD[23:16] + ID_WORD[15:8] + ID_WORD[7:0];
	// a commanded fault spoils the checksum only
	assign image = {ID_WORD, sum ^ {8{corrupt}}};
	// deselected line shows the inverse so a stale bit never passes as good
	assign rom_sdata = rom_cs ? last : ~last;

	initial last = 1'b0;

	always @(posedge rom_sclk or negedge rom_cs) begin
		if (!rom_cs) begin
			idx = 0;
		end else if (idx < 40) begin
			last = image[39 - idx];
			idx  = idx + 1;
		end
	end
endmodule : serial_rom_model

`default_nettype wire

// [tb_top.sv]
// self-checking bench for the upper config registers
// assumes a 100 MHz clock and a shortened serial rom load
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	localparam int          LOAD_CYC = 400;
	localparam logic [31:0] ID_WORD  = 32'h3C5A0F1E;
	localparam logic [15:0] LAT_GNT  = {cfg_upper_pkg::MAX_LATENCY_FIELD_VAL, cfg_upper_pkg::MIN_GNT_VAL};

	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        ce = 1'b1;
	logic        cfg_req = 1'b0;
	logic        cfg_we = 1'b0;
	logic [5:0]  cfg_addr = 6'h00;
	logic [3:0]  cfg_be = 4'h0;
	logic [31:0] cfg_wdata = 32'h0;
	logic        cfg_ack, cfg_retry;
	logic [31:0] cfg_rdata;
	logic        mem_space_en = 1'b0;
	logic        mem_req = 1'b0;
	logic [31:0] mem_addr = 32'h0;
	logic        csr_hit, rom_hit, rom_cs, rom_sclk, rom_sdata;
	logic        corrupt = 1'b0;
	int          miscompares = 0;
	int          total_checks = 0;

	always #5 clk = ~clk;

	pci_config_space_upper_regs #(.LOAD_CYCLES(LOAD_CYC)) pci_config_space_upper_regs_inst (
		.clk(clk), .rstn(rstn), .ce(ce), .cfg_req(cfg_req), .cfg_we(cfg_we),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack),
		.cfg_retry(cfg_retry), .cfg_rdata(cfg_rdata), .mem_space_en(mem_space_en),
		.mem_req(mem_req), .mem_addr(mem_addr), .csr_hit(csr_hit), .rom_hit(rom_hit),
		.rom_cs(rom_cs), .rom_sclk(rom_sclk), .rom_sdata(rom_sdata));

	serial_rom_model #(.ID_WORD(ID_WORD)) serial_rom_model_inst (
		.rom_cs(rom_cs), .rom_sclk(rom_sclk), .rom_sdata(rom_sdata), .corrupt(corrupt));

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic access(input logic we, input logic [7:0] off, input logic [3:0] be, input logic [31:0] wd);
		@(posedge clk);
		cfg_req   <= 1'b1;
		cfg_we    <= we;
		cfg_addr  <= off[7:2];
		cfg_be    <= be;
		cfg_wdata <= wd;
		@(posedge clk);
		cfg_req <= 1'b0;
		#1;
	endtask : access

	task automatic rd(input logic [7:0] off, input logic [31:0] exp);
		access(1'b0, off, 4'hF, 32'h0);
		check("read ack", 32'h1, {31'h0, cfg_ack});
		check("read data", exp, cfg_rdata);
	endtask : rd

	task automatic wr(input logic [7:0] off, input logic [3:0] be, input logic [31:0] wd);
		access(1'b1, off, be, wd);
		check("write ack", 32'h1, {31'h0, cfg_ack});
	endtask : wr

	task automatic rd_refused();
		access(1'b0, 8'h2C, 4'hF, 32'h0);
		check("retry", 32'h1, {31'h0, cfg_retry});
		check("no ack", 32'h0, {31'h0, cfg_ack});
	endtask : rd_refused

	task automatic do_reset();
		rstn <= 1'b0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
	endtask : do_reset

	task automatic probe(input logic sp, input logic [31:0] a, input logic ec, input logic er);
		@(posedge clk);
		mem_space_en <= sp;
		mem_req      <= 1'b1;
		mem_addr     <= a;
		#1;
		check("csr hit", {31'h0, ec}, {31'h0, csr_hit});
		check("rom hit", {31'h0, er}, {31'h0, rom_hit});
	endtask : probe

	task automatic t_load();
		rd_refused();
		check("rom cs", 32'h1, {31'h0, rom_cs});
		repeat (LOAD_CYC - 40) @(posedge clk);
		rd_refused();
		repeat (60) @(posedge clk);
		rd(8'h2C, ID_WORD);
		check("rom cs off", 32'h0, {31'h0, rom_cs});
		wr(8'h2C, 4'hF, 32'hFFFFFFFF);
		rd(8'h2C, ID_WORD);
	endtask : t_load

	task automatic t_fields();
		rd(8'h3C, {LAT_GNT, 8'h01, 8'h00});
		wr(8'h14, 4'hF, 32'hFFFFFFFF);
		rd(8'h14, 32'hFFFFFF80);
		wr(8'h30, 4'hF, 32'hFFFFFFFF);
		rd(8'h30, 32'hFFFC0001);
		wr(8'h3C, 4'hF, 32'hFFFFFFFF);
		wr(8'h3C, 4'hE, 32'h00000000);
		rd(8'h3C, {LAT_GNT, 8'h01, 8'hFF});
		wr(8'h40, 4'h5, 32'hA5A5A5A5);
		rd(8'h40, 32'h00A500A5);
		// clock enable low: request must be ignored
		@(posedge clk);
		ce <= 1'b0;
		access(1'b1, 8'h40, 4'hF, 32'hFFFFFFFF);
		check("frozen ack", 32'h0, {31'h0, cfg_ack});
		@(posedge clk);
		ce <= 1'b1;
		rd(8'h40, 32'h00A500A5);
		wr(8'h44, 4'hF, 32'hFFFFFFFF);
		rd(8'h44, 32'h00000000);
	endtask : t_fields

	task automatic t_decode();
		wr(8'h14, 4'hF, 32'h123456FF);
		rd(8'h14, 32'h12345680);
		wr(8'h30, 4'hF, 32'hABCC0001);
		probe(1'b1, 32'h123456FC, 1'b1, 1'b0);
		probe(1'b1, 32'h12345700, 1'b0, 1'b0);
		probe(1'b0, 32'h12345680, 1'b0, 1'b0);
		probe(1'b1, 32'hABCFFFFC, 1'b0, 1'b1);
		probe(1'b1, 32'hABD00000, 1'b0, 1'b0);
		probe(1'b0, 32'hABCC0000, 1'b0, 1'b0);
		wr(8'h30, 4'h1, 32'h00000000);
		probe(1'b1, 32'hABCC0000, 1'b0, 1'b0);
		mem_req <= 1'b0;
	endtask : t_decode

	task automatic t_bad_sum();
		corrupt <= 1'b1;
		do_reset();
		rd_refused();
		repeat (LOAD_CYC + 30) @(posedge clk);
		rd(8'h2C, 32'h00000000);
		rd(8'h14, 32'h00000000);
	endtask : t_bad_sum

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test

	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		finish_test();
	end

	initial begin
		do_reset();
		t_load();
		t_fields();
		t_decode();
		t_bad_sum();
		finish_test();
	end
endmodule : tb_top

`default_nettype wire
